// file: sar_cfg.svh
// constants for the converter control and serial readout block
// assumes a 250 MHz core clock; included by bare name
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

// result width and core clock period
`define SAR_RES_BITS      16
`define SAR_CLK_PERIOD_NS 4

// one successive-approximation step, least time, rounded up to cycles
`define SAR_STEP_NS       30
`define SAR_STEP_CYC      ((`SAR_STEP_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)

// trial code at conversion start and result after reset
`define SAR_MSB_TRIAL     16'h8000
`define SAR_RESULT_RST    16'h0000

// bit positions and serial edge count
`define SAR_MSB_IDX       4'hf
`define SAR_LAST_EDGE     5'h10

`endif

// file: sar_pkg.sv
// types shared by the converter control and its serial-clock counter
// assumes sar_cfg.svh is included by the files that use the constants
package sar_pkg;

  // conversion engine states
  typedef enum logic [1:0] {
    CONV_ACQ = 2'b00,
    CONV_RUN = 2'b01
  } sar_conv_st_t;

  // readout states
  typedef enum logic [1:0] {
    RD_IDLE  = 2'b00,
    RD_WAIT  = 2'b01,
    RD_SHIFT = 2'b10
  } sar_rd_st_t;

  // one bit each of the levels that cross into the core clock domain
  typedef struct packed {
    logic convert_start;
    logic chain_input;
    logic done;
  } sar_sync_t;

  // whole state of the core-clock logic
  typedef struct packed {
    sar_sync_t    s1;
    sar_sync_t    s2;
    logic         cnv_d;
    logic         sdi_d;
    sar_conv_st_t cst;
    logic [3:0]   sar_bit;
    logic [3:0]   step_cnt;
    logic [15:0]  trial;
    logic [15:0]  result;
    logic         res_ok;
    logic         busy;
    logic         pwr_down;
    logic         chain_mode;
    sar_rd_st_t   rst;
    logic         four_wire;
    logic         clr;
    logic         oe;
    logic         show;
  } sar_core_st_t;

  // whole state of the serial-clock logic
  typedef struct packed {
    logic [4:0] cnt;
  } sar_sck_st_t;

endpackage : sar_pkg

// file: sar_sck_counter.sv
// serial-clock domain: counts falling edges of the serial clock
// assumes the clear comes from a core flip-flop and the clock is idle when it falls
`timescale 1ns/1ps
`include "sar_cfg.svh"

module sar_sck_counter
  import sar_pkg::*;
(
  // serial clock from the host
  input  wire logic       sck_i,
  // hold cleared while no readout runs, from a core register
  input  wire logic       clr_i,
  // falling edges seen since the clear released
  output logic [4:0]      cnt_o,
  // sixteen edges seen
  output logic            done_o
);

  sar_sck_st_t q;
  sar_sck_st_t n;

  // advance one bit per falling edge, stop at the last one
  always_comb begin
    n = q;
    if (q.cnt != `SAR_LAST_EDGE) begin
      n.cnt = q.cnt + 5'h01;
    end
  end

  always_ff @(negedge sck_i or posedge clr_i) begin
    if (clr_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign cnt_o  = q.cnt;
  assign done_o = (q.cnt == `SAR_LAST_EDGE);

endmodule : sar_sck_counter

// file: sar_adc_readout.sv
// conversion start, successive approximation and select-gated serial readout
// assumes a latched comparator on the core clock and a host that clocks the data out
`timescale 1ns/1ps
`include "sar_cfg.svh"

module sar_adc_readout
  import sar_pkg::*;
(
  // core clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  // host pins
  input  wire logic        CONVERT_START_I,
  input  wire logic        CHAIN_INPUT_I,
  input  wire logic        SCLK_I,
  output logic             SERIAL_OUT_O,
  output logic             SERIAL_OUT_OE_O,
  // analog core
  input  wire logic        CMP_I,
  output logic [15:0]      DAC_CODE_O,
  output logic             HOLD_O,
  output logic             POWER_DOWN_O,
  // status
  output logic             CHAIN_MODE_O,
  output logic             RESULT_READY_O
);

  sar_core_st_t q;
  sar_core_st_t n;

  // serial-clock side
  logic [4:0]   sck_cnt;
  logic         sck_done;

  // edges and levels of the synchronised pins, step end, comparator decision and output bit index
  logic         cnv_rise;
  logic         sdi_rise;
  logic         both_low;
  logic         step_end;
  logic [15:0]  decided;
  logic [3:0]   out_idx;

  // serial-clock edge counter, cleared from the core while no readout runs
  sar_sck_counter u_sck (
    .sck_i  (SCLK_I),
    .clr_i  (q.clr),
    .cnt_o  (sck_cnt),
    .done_o (sck_done)
  );

  // edge detection reads only the second synchroniser stage
  assign cnv_rise = q.s2.convert_start & ~q.cnv_d;
  assign sdi_rise = q.s2.chain_input & ~q.sdi_d;
  assign both_low = ~q.s2.convert_start & ~q.s2.chain_input;

  assign step_end = (q.step_cnt == 4'(`SAR_STEP_CYC - 1));

  // bit position shown on the data pin
  assign out_idx = `SAR_MSB_IDX - sck_cnt[3:0];

  // comparator decision applied to the bit under trial
  always_comb begin
    decided = q.trial;
    // drop bit when input below trial
    if (!CMP_I) begin
      decided[q.sar_bit] = 1'b0;
    end
  end

  // next state of the whole core
  always_comb begin
    n = q;

    // two-stage synchronisers for pins and the edge-count flag
    n.s1.convert_start  = CONVERT_START_I;
    n.s1.chain_input  = CHAIN_INPUT_I;
    n.s1.done = sck_done;
    n.s2      = q.s1;
    n.cnv_d   = q.s2.convert_start;
    n.sdi_d   = q.s2.chain_input;

    // mode taken at each start edge
    if (cnv_rise) begin
      n.chain_mode = ~q.sdi_d;
    end

    // conversion engine
    case (q.cst)
      CONV_ACQ: begin
        if (cnv_rise) begin
          n.cst      = CONV_RUN;
          n.trial    = `SAR_MSB_TRIAL;
          n.sar_bit  = `SAR_MSB_IDX;
          n.step_cnt = 4'h0;
          n.res_ok   = 1'b0;
          n.busy     = 1'b1;
          n.pwr_down = 1'b0;
        end
      end
      CONV_RUN: begin
        if (step_end) begin
          n.step_cnt = 4'h0;
          n.trial    = decided;
          if (q.sar_bit == 4'h0) begin
            n.result   = decided;
            n.res_ok   = 1'b1;
            n.cst      = CONV_ACQ;
            n.busy     = 1'b0;
            n.pwr_down = 1'b1;
          end else begin
            n.sar_bit                      = q.sar_bit - 4'h1;
            n.trial[q.sar_bit - 4'h1]      = 1'b1;
          end
        end else begin
          n.step_cnt = q.step_cnt + 4'h1;
        end
      end
      default: begin
        n.cst      = CONV_ACQ;
        n.busy     = 1'b0;
        n.pwr_down = 1'b1;
      end
    endcase

    // readout sequencing
    case (q.rst)
      RD_IDLE: begin
        n.oe   = 1'b0;
        n.show = 1'b0;
        n.clr  = 1'b1;
      end
      RD_WAIT: begin
        // host waits, readout only once result stands
        if (q.res_ok && (q.cst == CONV_ACQ) && !q.chain_mode) begin
          if (!q.s2.convert_start && q.s2.chain_input) begin
            n.rst       = RD_SHIFT;
            n.four_wire = 1'b0;
            n.clr       = 1'b0;
            n.oe        = 1'b1;
            n.show      = 1'b1;
          end else if (q.s2.convert_start && !q.s2.chain_input) begin
            n.rst       = RD_SHIFT;
            n.four_wire = 1'b1;
            n.clr       = 1'b0;
            n.oe        = 1'b1;
            n.show      = 1'b1;
          end
        end
      end
      RD_SHIFT: begin
        if (q.s2.done) begin
          n.rst  = RD_IDLE;
          n.oe   = 1'b0;
          n.show = 1'b0;
          n.clr  = 1'b1;
        end else if (q.four_wire && sdi_rise) begin
          n.rst  = RD_IDLE;
          n.oe   = 1'b0;
          n.show = 1'b0;
          n.clr  = 1'b1;
        end else if (q.four_wire && !q.s2.convert_start) begin
          // start must stay high, give up
          n.rst  = RD_IDLE;
          n.oe   = 1'b0;
          n.show = 1'b0;
          n.clr  = 1'b1;
        end
      end
      default: begin
        n.rst  = RD_IDLE;
        n.oe   = 1'b0;
        n.show = 1'b0;
        n.clr  = 1'b1;
      end
    endcase

    if (cnv_rise) begin
      n.rst  = RD_WAIT;
      n.oe   = 1'b0;
      n.show = 1'b0;
      n.clr  = 1'b1;
    end

    if (n.rst != RD_SHIFT) begin
      n.oe   = both_low;
      n.show = 1'b0;
    end
  end

  // register the whole core state
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      q            <= '0;
      q.cst        <= CONV_ACQ;
      q.rst        <= RD_IDLE;
      q.result     <= `SAR_RESULT_RST;
      q.pwr_down   <= 1'b1;
      q.clr        <= 1'b1;
      // chain input idles high: no false drive-low or select edge after reset
      q.s1.chain_input     <= 1'b1;
      q.s2.chain_input     <= 1'b1;
      q.sdi_d      <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign SERIAL_OUT_O    = q.show & ~sck_cnt[4] & q.result[out_idx];
  assign SERIAL_OUT_OE_O = q.oe;

  // analog core controls
  assign DAC_CODE_O      = q.trial;
  assign HOLD_O          = q.busy;      // track-and-hold in hold
  assign POWER_DOWN_O    = q.pwr_down;  // low only while converting

  // status
  assign CHAIN_MODE_O    = q.chain_mode;
  assign RESULT_READY_O  = q.res_ok;

endmodule : sar_adc_readout

// file: sar_adc_readout_chk.sv
// port checker for conversion control and select-gated readout
// assumes core clock domain only; bound onto sar_adc_readout
`timescale 1ns/1ps
module sar_adc_readout_chk (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // host pins
  input wire logic CONVERT_START_I,
  input wire logic CHAIN_INPUT_I,
  input wire logic SERIAL_OUT_O,
  input wire logic SERIAL_OUT_OE_O,
  // status
  input wire logic HOLD_O,
  input wire logic POWER_DOWN_O,
  input wire logic CHAIN_MODE_O,
  input wire logic RESULT_READY_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // conversion span, power state and readiness
  conv_span_a: assert property (
    $rose(HOLD_O) |-> ##[127:129] $fell(HOLD_O)) else $error("conversion span");
  pd_level_a: assert property (
    POWER_DOWN_O != HOLD_O) else $error("power state");
  done_ready_a: assert property (
    $fell(HOLD_O) |-> RESULT_READY_O) else $error("no ready");
  // start floats output; mode from chain level before the start
  start_float_a: assert property (
    $rose(HOLD_O) |-> !SERIAL_OUT_OE_O) else $error("driven at start");
  mode_pick_a: assert property (
    $rose(HOLD_O) |-> CHAIN_MODE_O == !$past(CHAIN_INPUT_I, 6)) else $error("mode");
  // output release and drive-low
  cnv_float_a: assert property (
    $rose(CONVERT_START_I) |-> ##[1:5] !SERIAL_OUT_OE_O) else $error("cnv release");
  sel_float_a: assert property (
    CONVERT_START_I && $rose(CHAIN_INPUT_I) |-> ##[1:5] !SERIAL_OUT_OE_O)
    else $error("select release");
  drive_low_a: assert property (
    (!CONVERT_START_I && !CHAIN_INPUT_I)[*5] |-> SERIAL_OUT_OE_O && !SERIAL_OUT_O)
    else $error("drive low");
endmodule : sar_adc_readout_chk

bind sar_adc_readout sar_adc_readout_chk sar_adc_readout_chk_inst (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CONVERT_START_I(CONVERT_START_I),
  .CHAIN_INPUT_I(CHAIN_INPUT_I), .SERIAL_OUT_O(SERIAL_OUT_O),
  .SERIAL_OUT_OE_O(SERIAL_OUT_OE_O), .HOLD_O(HOLD_O), .POWER_DOWN_O(POWER_DOWN_O),
  .CHAIN_MODE_O(CHAIN_MODE_O), .RESULT_READY_O(RESULT_READY_O));

// file: sar_host.sv
// host model: convert-start, chain input and serial clock
// assumes core clock for pin timing; serial clock only runs in frames
`timescale 1ns/1ps
module sar_host (
  // core clock
  input  wire logic clk_i,
  // pins toward the converter
  output logic      cnv_o,
  output logic      sdi_o,
  output logic      sclk_o,
  // serial data back
  input  wire logic sdo_i
);
  // idle levels, serial clock low
  initial begin
    cnv_o = 1'b0;
    sdi_o = 1'b1;
    sclk_o = 1'b0;
  end
  // set both pins after a core edge, hold n cycles
  task pins(input logic c, input logic s, input int n);
    @(posedge clk_i);
    cnv_o <= c;
    sdi_o <= s;
    repeat (n) @(posedge clk_i);
  endtask : pins
  task wait_conv();
    repeat (140) @(posedge clk_i);
  endtask : wait_conv
  // capture on rise, device shifts on fall
  task read(input int n, output logic [15:0] w);
    w = 16'h0000;
    #3;
    repeat (n) begin
      #6 sclk_o = 1'b1;
      w = {w[14:0], sdo_i};
      #6 sclk_o = 1'b0;
    end
  endtask : read
endmodule : sar_host

// file: sar_adc_readout_tb.sv
// testbench: conversions, 3-wire and 4-wire readout, drive-low, mode pick
// assumes the host model drives pins and a comparator model follows the code
`timescale 1ns/1ps
module sar_adc_readout_tb;
  logic        CLK_I = 1'b0;
  logic        SYS_RST_I = 1'b1;
  logic        cmp = 1'b0;
  logic        convert_start, chain_input, sclk, so, oe, hold, pd, chm, rdy;
  logic [15:0] dac, w;
  int          vin = 0;
  int          err_count = 0;
  int          tests_run = 0;
  always #2 CLK_I = ~CLK_I;
  // comparator: analog level against trial code
  always @(posedge CLK_I) cmp <= (vin >= int'(dac));
  sar_host sar_host_inst (.clk_i(CLK_I), .cnv_o(convert_start), .sdi_o(chain_input), .sclk_o(sclk), .sdo_i(so));
  sar_adc_readout sar_adc_readout_inst (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .CONVERT_START_I(convert_start), .CHAIN_INPUT_I(chain_input), .SCLK_I(sclk), .SERIAL_OUT_O(so),
    .SERIAL_OUT_OE_O(oe), .CMP_I(cmp), .DAC_CODE_O(dac), .HOLD_O(hold),
    .POWER_DOWN_O(pd), .CHAIN_MODE_O(chm), .RESULT_READY_O(rdy));
  task check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task conclude();
    $display("checks=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // bounded wait for the output enable level
  task wait_oe(input logic v);
    repeat (20) if (oe !== v) @(posedge CLK_I);
    check(oe, v);
  endtask : wait_oe
  // 3-wire conversion and full readout
  task three_wire(input int v, input logic [15:0] e);
    vin = v;
    sar_host_inst.pins(1'b1, 1'b1, 5);
    check(oe, 1'b0);
    sar_host_inst.wait_conv();
    check({rdy, pd, hold, chm}, 4'b1100);
    check(dac, e);
    sar_host_inst.pins(1'b0, 1'b1, 0);
    wait_oe(1'b1);
    sar_host_inst.read(16, w);
    check(w, e);
    wait_oe(1'b0);
  endtask : three_wire
  // readout cut short by a new start
  task cut_short();
    vin = 'h1234;
    sar_host_inst.pins(1'b1, 1'b1, 5);
    sar_host_inst.wait_conv();
    sar_host_inst.pins(1'b0, 1'b1, 0);
    wait_oe(1'b1);
    sar_host_inst.read(5, w);
    check(w, 16'h0002);
    sar_host_inst.pins(1'b1, 1'b1, 5);
    check(oe, 1'b0);
    sar_host_inst.wait_conv();
  endtask : cut_short
  // 4-wire: chain input used elsewhere early, then selects this part
  task four_wire();
    vin = 'h5a5a;
    sar_host_inst.pins(1'b0, 1'b1, 8);
    sar_host_inst.pins(1'b1, 1'b1, 8);
    // back high well before conversion ends
    sar_host_inst.pins(1'b1, 1'b0, 8);
    sar_host_inst.pins(1'b1, 1'b1, 0);
    check(oe, 1'b0);
    sar_host_inst.wait_conv();
    sar_host_inst.pins(1'b1, 1'b0, 0);
    wait_oe(1'b1);
    sar_host_inst.read(8, w);
    check(w, 16'h005a);
    sar_host_inst.pins(1'b1, 1'b1, 0);
    wait_oe(1'b0);
  endtask : four_wire
  // pins tied together: chain mode, both low drive low
  task tied();
    sar_host_inst.pins(1'b0, 1'b0, 8);
    check({oe, so}, 2'b10);
    sar_host_inst.pins(1'b1, 1'b1, 0);
    sar_host_inst.wait_conv();
    check(chm, 1'b1);
    sar_host_inst.pins(1'b0, 1'b0, 8);
    check({oe, so}, 2'b10);
  endtask : tied
  // main sequence
  initial begin
    repeat (10) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    check({oe, hold, pd, rdy, chm}, 5'b00100);
    three_wire(-5, 16'h0000);
    three_wire(0, 16'h0000);
    three_wire('h8000, 16'h8000);
    three_wire('ha5c3, 16'ha5c3);
    three_wire('h1ffff, 16'hffff);
    cut_short();
    four_wire();
    tied();
    conclude();
  end
  // watchdog
  initial begin
    #50us;
    err_count++;
    conclude();
  end
endmodule : sar_adc_readout_tb
